// ===== src/extension_enable_config_exec.v
`timescale 1ns/1ns
`include "extension_enable_config_exec_consts.vh"
// Functional notes
// - zero test skip discards fetched next instruction, runs a no-op cycle
// - skip over two-word instruction costs three cycles total
// - bank bit 0 uses access bank, 1 uses bank select register
// - with extension and bank bit 0, operand up to 5Fh offsets third pointer
// - xor literal into working register, updates negative and zero flags, one cycle
// - xor with register: destination bit picks working register or register
// - extended instructions and indexed offset mode need the extension bit
// - five extended opcodes decoded besides the standard set
// - pointer add: six-bit literal added to pointer 0..2, no flags, one cycle
// - select 11 adds to third pointer then returns, second cycle no-op
// - pointer subtract: literal taken from selected pointer, no flags, one cycle
// - subtract form with select 11 uses third pointer then returns, two cycles
// - literal push writes at third pointer then decrements it, one cycle
// - indexed moves are two words, two cycles; second word starts 1111
// - call via working register pushes counter+2, loads counter from latches
// - call via working register saves no shadow registers
// - table write post-increment writes then advances; pre-increment advances first
// - table pointer low three bits select one of eight holding registers
// - indexed move source on an indirect register reads zero
// - indexed-to-indexed move onto an indirect register does nothing
module cpu_extended_instruction_execute #(
	parameter PC_W = 21
) (
	// clock and reset
	input wire core_clk,
	input wire nrst,
	// configuration
	input wire extensionEnableConfig,
	// instruction issue: one word per cycle
	input wire instrValid,
	input wire [15:0] instrWord,
	input wire [PC_W-1:0] programCounter,
	input wire [7:0] counterHighLatch,
	input wire [7:0] counterUpperLatch,
	input wire [PC_W-1:0] topOfReturnStack,
	input wire [7:0] bankSelectRegister,
	input wire [7:0] tableLatch,
	// data memory read port (combinational, same cycle)
	output wire [11:0] dataRdAddr,
	input wire [7:0] dataRdData,
	// data memory write port
	output reg dataWrEn,
	output reg [11:0] dataWrAddr,
	output reg [7:0] dataWrData,
	// program flow
	output reg pcLoad,
	output reg [PC_W-1:0] pcLoadValue,
	output reg stackPush,
	output reg [PC_W-1:0] stackPushValue,
	output reg stackPop,
	output wire squash,
	// architectural state
	output wire [7:0] workingRegister,
	output wire flagNegative,
	output wire flagZero,
	output wire [11:0] pointer0,
	output wire [11:0] pointer1,
	output wire [11:0] pointer2,
	output wire [21:0] tablePointer,
	// holding register write
	output reg holdWrEn,
	output reg [2:0] holdWrIdx,
	output reg [7:0] holdWrData
);

	////////////////////////////////////////////////////////////////////////
	localparam ST_EXEC = 3'b001;
	localparam ST_SKIP = 3'b010;
	localparam ST_MOVE = 3'b100;

	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	// high once no further word may be discarded in this run of no-ops
	reg skipsLeft_ff;
	reg nxt_skipsLeft;
	reg [7:0] workReg_ff;
	reg [7:0] nxt_workReg;
	reg negFlag_ff;
	reg nxt_negFlag;
	reg zeroFlag_ff;
	reg nxt_zeroFlag;
	reg [11:0] ptr0_ff;
	reg [11:0] ptr1_ff;
	reg [11:0] ptr2_ff;
	reg [11:0] nxt_ptr0;
	reg [11:0] nxt_ptr1;
	reg [11:0] nxt_ptr2;
	reg [21:0] table_pointer_ff;
	reg [21:0] nxt_table_pointer;
	reg [7:0] moveData_ff;
	reg [7:0] nxt_moveData;
	reg moveIndexed_ff;
	reg nxt_moveIndexed;
	reg [11:0] rdAddr;

	assign workingRegister = workReg_ff;
	assign flagNegative = negFlag_ff;
	assign flagZero = zeroFlag_ff;
	assign pointer0 = ptr0_ff;
	assign pointer1 = ptr1_ff;
	assign pointer2 = ptr2_ff;
	assign tablePointer = table_pointer_ff;
	assign dataRdAddr = rdAddr;
	assign squash = (state_ff != ST_EXEC);

	////////////////////////////////////////////////////////////////////////
	// byte operand address: access bank, banked or indexed from third pointer
	function [11:0] fileAddr;
		input [7:0] f;
		input a;
		input ext;
		input [7:0] bankSel;
		input [11:0] p2;
		begin
			if (a) begin
				fileAddr = {bankSel[3:0], f};
			end else if (ext && f <= `IDX_LIMIT) begin
				fileAddr = p2 + {4'h0, f};
			end else if (f <= `IDX_LIMIT) begin
				fileAddr = {4'h0, f};
			end else begin
				fileAddr = {4'hF, f};
			end
		end
	endfunction

	function isIndirect;
		input [11:0] adr;
		begin
			isIndirect = (adr >= `INDF_LO) && (adr <= `INDF_HI) &&
				((adr[2:0] == 3'h3) || (adr[2:0] == 3'h4) || (adr[2:0] == 3'h5) ||
				(adr[2:0] == 3'h6) || (adr[2:0] == 3'h7));
		end
	endfunction

	function isTwoWord;
		input [15:0] w;
		begin
			isTwoWord = (w[15:9] == `OPC_CALL_HI) || (w[15:8] == `OPC_LFSR_HI) ||
				(w[15:12] == `OPC_MOVFF_HI) || (w[15:8] == `OPC_GOTO_HI) ||
				(w[15:8] == `OPC_MOVS_HI && extensionEnableConfig);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// decode of the word in execute
	wire [7:0] opHi = instrWord[15:8];
	wire extOn = extensionEnableConfig;
	wire isTestSkip = (instrWord[15:9] == `OPC_TEST_SKIP_HI);
	wire isXorLit = (opHi == `OPC_XOR_LIT_HI);
	wire isXorReg = (instrWord[15:10] == `OPC_XOR_REG_HI);
	wire isTableWrite = (instrWord[15:2] == `OPC_TABLE_WRITE_HI);
	wire isPtrAdd = extOn && (opHi == `OPC_PTR_ADD_HI);
	wire isPtrSub = extOn && (opHi == `OPC_PTR_SUB_HI);
	wire isLitPush = extOn && (opHi == `OPC_LIT_PUSH_HI);
	wire isMovs = extOn && (opHi == `OPC_MOVS_HI);
	wire isCallViaW = extOn && (instrWord == `OPC_CALL_VIA_W);
	wire [11:0] byteAddr = fileAddr(instrWord[7:0], instrWord[8], extOn, bankSelectRegister, ptr2_ff);
	wire [11:0] srcAddr = ptr2_ff + {5'h00, instrWord[6:0]};
	wire [11:0] dstIdxAddr = ptr2_ff + {5'h00, instrWord[6:0]};
	wire [7:0] xorReg = workReg_ff ^ dataRdData;
	wire [7:0] xorLit = workReg_ff ^ instrWord[7:0];
	wire [11:0] kExt = {6'h00, instrWord[5:0]};
	wire [1:0] ptrSel = instrWord[7:6];

	always @* begin
		rdAddr = byteAddr;
		if (state_ff == ST_EXEC && isMovs) begin
			rdAddr = srcAddr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always @* begin
		nxt_state = state_ff;
		nxt_skipsLeft = skipsLeft_ff;
		nxt_workReg = workReg_ff;
		nxt_negFlag = negFlag_ff;
		nxt_zeroFlag = zeroFlag_ff;
		nxt_ptr0 = ptr0_ff;
		nxt_ptr1 = ptr1_ff;
		nxt_ptr2 = ptr2_ff;
		nxt_table_pointer = table_pointer_ff;
		nxt_moveData = moveData_ff;
		nxt_moveIndexed = moveIndexed_ff;
		dataWrEn = 1'b0;
		dataWrAddr = `RESET_PTR;
		dataWrData = `RESET_BYTE;
		pcLoad = 1'b0;
		pcLoadValue = {PC_W{1'b0}};
		stackPush = 1'b0;
		stackPushValue = {PC_W{1'b0}};
		stackPop = 1'b0;
		holdWrEn = 1'b0;
		holdWrIdx = 3'h0;
		holdWrData = `RESET_BYTE;
		case (state_ff)
			ST_EXEC: begin
				if (instrValid) begin
					if (isTestSkip) begin
						if (dataRdData == `RESET_BYTE) begin
							nxt_state = ST_SKIP;
							nxt_skipsLeft = 1'b0;
						end
					end else if (isXorLit) begin
						nxt_workReg = xorLit;
						nxt_negFlag = xorLit[7];
						nxt_zeroFlag = (xorLit == `RESET_BYTE);
					end else if (isXorReg) begin
						nxt_negFlag = xorReg[7];
						nxt_zeroFlag = (xorReg == `RESET_BYTE);
						if (instrWord[9]) begin
							dataWrEn = 1'b1;
							dataWrAddr = byteAddr;
							dataWrData = xorReg;
						end else begin
							nxt_workReg = xorReg;
						end
					end else if (isTableWrite) begin
						holdWrEn = 1'b1;
						holdWrData = tableLatch;
						holdWrIdx = table_pointer_ff[2:0];
						case (instrWord[1:0])
							`TBL_MODE_POSTINC: nxt_table_pointer = table_pointer_ff + 22'h1;
							`TBL_MODE_POSTDEC: nxt_table_pointer = table_pointer_ff - 22'h1;
							`TBL_MODE_PREINC: begin
								nxt_table_pointer = table_pointer_ff + 22'h1;
								holdWrIdx = nxt_table_pointer[2:0];
							end
							default: nxt_table_pointer = table_pointer_ff;
						endcase
					end else if (isPtrAdd || isPtrSub) begin
						// full 12-bit add or subtract, no flags touched
						case (ptrSel)
							2'h0: nxt_ptr0 = isPtrAdd ? ptr0_ff + kExt : ptr0_ff - kExt;
							2'h1: nxt_ptr1 = isPtrAdd ? ptr1_ff + kExt : ptr1_ff - kExt;
							default: nxt_ptr2 = isPtrAdd ? ptr2_ff + kExt : ptr2_ff - kExt;
						endcase
						if (ptrSel == `PTR_SEL_RET) begin
							pcLoad = 1'b1;
							pcLoadValue = topOfReturnStack;
							stackPop = 1'b1;
							nxt_state = ST_SKIP;
							// only the word fetched before the return is dropped
							nxt_skipsLeft = 1'b1;
						end
					end else if (isLitPush) begin
						dataWrEn = 1'b1;
						dataWrAddr = ptr2_ff;
						dataWrData = instrWord[7:0];
						nxt_ptr2 = ptr2_ff - 12'h001;
					end else if (isMovs) begin
						nxt_moveData = isIndirect(srcAddr) ? `RESET_BYTE : dataRdData;
						nxt_moveIndexed = instrWord[7];
						nxt_state = ST_MOVE;
					end else if (isCallViaW) begin
						// no shadow save of working, status or bank registers
						stackPush = 1'b1;
						stackPushValue = programCounter + {{(PC_W-2){1'b0}}, 2'h2};
						pcLoad = 1'b1;
						pcLoadValue = {counterUpperLatch[PC_W-17:0], counterHighLatch, workReg_ff};
						nxt_state = ST_SKIP;
						// second cycle is one no-op whatever word was fetched
						nxt_skipsLeft = 1'b1;
					end
				end
			end
			ST_SKIP: begin
				if (instrValid) begin
					// a skipped two-word instruction costs one more no-op;
					// a flow change enters with skipsLeft_ff set, so it
					// discards exactly the one word already fetched
					if (!skipsLeft_ff && isTwoWord(instrWord)) begin
						nxt_skipsLeft = 1'b1;
					end else begin
						nxt_state = ST_EXEC;
						nxt_skipsLeft = 1'b0;
					end
				end
			end
			ST_MOVE: begin
				if (instrValid) begin
					nxt_state = ST_EXEC;
					// any other second word writes nothing
					if (instrWord[15:12] == `OPC_SECOND_HI) begin
						if (moveIndexed_ff) begin
							if (!isIndirect(dstIdxAddr)) begin
								dataWrEn = 1'b1;
								dataWrAddr = dstIdxAddr;
								dataWrData = moveData_ff;
							end
						end else begin
							dataWrEn = 1'b1;
							dataWrAddr = instrWord[11:0];
							dataWrData = moveData_ff;
						end
					end
				end
			end
			default: begin
				nxt_state = ST_EXEC;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		// all architectural state clears on a low reset at the edge
		if (!nrst) begin
			state_ff <= ST_EXEC;
			skipsLeft_ff <= 1'b0;
			workReg_ff <= `RESET_BYTE;
			negFlag_ff <= 1'b0;
			zeroFlag_ff <= 1'b0;
			ptr0_ff <= `RESET_PTR;
			ptr1_ff <= `RESET_PTR;
			ptr2_ff <= `RESET_PTR;
			table_pointer_ff <= 22'h000000;
			moveData_ff <= `RESET_BYTE;
			moveIndexed_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			skipsLeft_ff <= nxt_skipsLeft;
			workReg_ff <= nxt_workReg;
			negFlag_ff <= nxt_negFlag;
			zeroFlag_ff <= nxt_zeroFlag;
			ptr0_ff <= nxt_ptr0;
			ptr1_ff <= nxt_ptr1;
			ptr2_ff <= nxt_ptr2;
			table_pointer_ff <= nxt_table_pointer;
			moveData_ff <= nxt_moveData;
			moveIndexed_ff <= nxt_moveIndexed;
		end
	end

endmodule // cpu_extended_instruction_execute

// ===== src/extension_enable_config_exec_consts.vh
`ifndef EXT_EXEC_CONSTS_VH
`define EXT_EXEC_CONSTS_VH
// opcode patterns (upper bits of the 16-bit word)
`define OPC_TEST_SKIP_HI 7'h33
`define OPC_XOR_LIT_HI 8'h0A
`define OPC_XOR_REG_HI 6'h06
`define OPC_PTR_ADD_HI 8'hE8
`define OPC_PTR_SUB_HI 8'hE9
`define OPC_LIT_PUSH_HI 8'hEA
`define OPC_MOVS_HI 8'hEB
`define OPC_SECOND_HI 4'hF
`define OPC_CALL_VIA_W 16'h0014
`define OPC_TABLE_WRITE_HI 14'h0003
// two-word instruction first-word patterns (call, lfsr, movff, goto)
`define OPC_CALL_HI 7'h76
`define OPC_LFSR_HI 8'hEE
`define OPC_MOVFF_HI 4'hC
`define OPC_GOTO_HI 8'hEF
// indexed literal offset limit
`define IDX_LIMIT 8'h5F
// indirect addressing register window in data space
`define INDF_LO 12'hFDB
`define INDF_HI 12'hFEF
`define TBL_MODE_NONE 2'h0
`define TBL_MODE_POSTINC 2'h1
`define TBL_MODE_POSTDEC 2'h2
`define TBL_MODE_PREINC 2'h3
`define PTR_THIRD 2'h2
`define PTR_SEL_RET 2'h3
`define RESET_BYTE 8'h00
`define RESET_PTR 12'h000
`endif

// ===== verification/data_mem_model.sv
`timescale 1ns/1ns
module data_mem_model (
	// clock
	input wire core_clk,
	// read port, same cycle
	input wire [11:0] rdAddr,
	output wire [7:0] rdData,
	// write port
	input wire wrEn,
	input wire [11:0] wrAddr,
	input wire [7:0] wrData
);
	reg [7:0] mem [0:4095];
	integer i;
	initial begin
		for (i = 0; i < 4096; i = i + 1) mem[i] = i[7:0] ^ 8'h5A;
	end
	assign rdData = mem[rdAddr];
	always @(posedge core_clk) begin
		if (wrEn) mem[wrAddr] <= wrData;
	end
endmodule // data_mem_model

// ===== verification/extension_enable_config_exec_chk.sv
`timescale 1ns/1ns
module cpu_extended_instruction_execute_chk #(parameter PC_W = 21) (
	// clock, reset and issue
	input wire core_clk,
	input wire nrst,
	input wire extensionEnableConfig,
	input wire instrValid,
	input wire [15:0] instrWord,
	input wire [PC_W-1:0] programCounter,
	input wire [7:0] counterHighLatch,
	input wire [7:0] counterUpperLatch,
	input wire [PC_W-1:0] topOfReturnStack,
	input wire [7:0] tableLatch,
	input wire [7:0] dataRdData,
	// results
	input wire dataWrEn,
	input wire [11:0] dataWrAddr,
	input wire [7:0] dataWrData,
	input wire pcLoad,
	input wire [PC_W-1:0] pcLoadValue,
	input wire stackPush,
	input wire [PC_W-1:0] stackPushValue,
	input wire stackPop,
	input wire squash,
	input wire [7:0] workingRegister,
	input wire flagNegative,
	input wire flagZero,
	input wire [11:0] pointer2,
	input wire [21:0] tablePointer,
	input wire holdWrEn,
	input wire [2:0] holdWrIdx,
	input wire [7:0] holdWrData
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire go = instrValid && !squash;
	wire ext = go && extensionEnableConfig;
	wire zt = go && instrWord[15:9] == 7'h33 && dataRdData == 8'h00;
	wire [23:0] callTarget = {counterUpperLatch, counterHighLatch, workingRegister};
	wire [11:0] lit = {6'h00, instrWord[5:0]};
	AST_XOR_LIT: assert property (go && instrWord[15:8] == 8'h0A |=>
		workingRegister == $past(workingRegister ^ instrWord[7:0]) && flagZero == (workingRegister == 8'h00)
		&& flagNegative == workingRegister[7]) else $error("xor literal wrong");
	AST_PUSH: assert property (ext && instrWord[15:8] == 8'hEA |-> dataWrEn && dataWrAddr == pointer2
		&& dataWrData == instrWord[7:0] ##1 pointer2 == $past(pointer2) - 12'h001) else $error("push wrong");
	AST_ADD: assert property (ext && instrWord[15:6] == 10'h3A2 |-> !pcLoad
		##1 pointer2 == $past(pointer2 + lit)) else $error("pointer add wrong");
	AST_SUB_RET: assert property (ext && instrWord[15:6] == 10'h3A7 |-> pcLoad && stackPop
		&& pcLoadValue == topOfReturnStack
		##1 squash && pointer2 == $past(pointer2 - lit)) else $error("sub return wrong");
	AST_CALL_W: assert property (ext && instrWord == 16'h0014 |-> stackPush && pcLoad
		&& stackPushValue == programCounter + 2 && pcLoadValue == callTarget[PC_W-1:0]
		##1 squash && workingRegister == $past(workingRegister)) else $error("call via w wrong");
	AST_EXT_OFF: assert property (instrValid && !extensionEnableConfig && instrWord[15:10] == 6'h3A
		|-> !dataWrEn && !pcLoad ##1 pointer2 == $past(pointer2)) else $error("extension off acted");
	AST_TBL: assert property (go && instrWord[15:2] == 14'h0003 |-> holdWrEn && holdWrData == tableLatch
		&& holdWrIdx == tablePointer[2:0] + (instrWord[1:0] == 2'h3)) else $error("table write wrong");
	AST_SKIP: assert property (zt |=> squash) else $error("skip missing");
	AST_SKIP_LONG: assert property (zt ##1 instrWord[15:8] == 8'hEF |=> squash) else $error("long skip short");
	AST_ADD_RET: assert property (ext && instrWord[15:6] == 10'h3A3 |-> pcLoad && stackPop
		&& pcLoadValue == topOfReturnStack ##1 squash && pointer2 == $past(pointer2 + lit))
		else $error("add return wrong");
	AST_RET_ONE: assert property (ext && instrWord[15:9] == 7'h74 && instrWord[7:6] == 2'h3 ##1 instrValid
		|=> !squash) else $error("return discarded two words");
	AST_MOVE_ABS: assert property (ext && instrWord[15:7] == 9'h1D6 ##1 instrValid && instrWord[15:12] == 4'hF
		|-> squash && dataWrEn && dataWrAddr == instrWord[11:0]) else $error("indexed move to absolute wrong");
endmodule // cpu_extended_instruction_execute_chk
bind cpu_extended_instruction_execute cpu_extended_instruction_execute_chk #(.PC_W(PC_W)) chk (
	.core_clk, .nrst, .extensionEnableConfig, .instrValid,
	.instrWord, .programCounter, .counterHighLatch, .counterUpperLatch, .topOfReturnStack, .tableLatch,
	.dataRdData, .dataWrEn, .dataWrAddr, .dataWrData, .pcLoad, .pcLoadValue, .stackPush, .stackPushValue,
	.stackPop, .squash, .workingRegister, .flagNegative, .flagZero, .pointer2, .tablePointer, .holdWrEn,
	.holdWrIdx, .holdWrData);

// ===== verification/extension_enable_config_exec_bench.sv
`timescale 1ns/1ns
module cpu_extended_instruction_execute_bench;
	reg core_clk = 1'b0, nrst = 1'b0, extensionEnableConfig = 1'b1, instrValid = 1'b0;
	reg [15:0] instrWord = 16'h0000;
	reg [20:0] programCounter = 21'h000100, topOfReturnStack = 21'h001234;
	reg [7:0] counterHighLatch = 8'h10, counterUpperLatch = 8'h00, bankSelectRegister = 8'h00, tableLatch = 8'h3C;
	wire [7:0] dataRdData, dataWrData, workingRegister, holdWrData;
	wire [11:0] dataRdAddr, dataWrAddr, pointer0, pointer1, pointer2;
	wire [20:0] pcLoadValue, stackPushValue;
	wire [21:0] tablePointer;
	wire [2:0] holdWrIdx;
	wire dataWrEn, pcLoad, stackPush, stackPop, squash, flagNegative, flagZero, holdWrEn;
	integer n_mismatch = 0, checks = 0, k;
	always #50 core_clk = ~core_clk;
	cpu_extended_instruction_execute dut (.core_clk, .nrst, .extensionEnableConfig, .instrValid, .instrWord,
		.programCounter,
		.counterHighLatch, .counterUpperLatch, .topOfReturnStack, .bankSelectRegister, .tableLatch, .dataRdAddr,
		.dataRdData, .dataWrEn, .dataWrAddr, .dataWrData, .pcLoad, .pcLoadValue, .stackPush, .stackPushValue,
		.stackPop, .squash, .workingRegister, .flagNegative, .flagZero, .pointer0, .pointer1, .pointer2,
		.tablePointer, .holdWrEn, .holdWrIdx, .holdWrData);
	data_mem_model mdl (.core_clk, .rdAddr(dataRdAddr), .rdData(dataRdData), .wrEn(dataWrEn),
		.wrAddr(dataWrAddr), .wrData(dataWrData));
	task chk(input string name, input [21:0] seen, input [21:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("BAD %0s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	task op(input [15:0] wd);
		begin
			@(negedge core_clk);
			instrValid = 1'b1;
			instrWord = wd;
		end
	endtask
	task idle;
		begin
			@(negedge core_clk);
			instrValid = 1'b0;
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", checks, n_mismatch);
			if (n_mismatch == 0 && checks > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask
	initial begin
		repeat (2000) @(posedge core_clk);
		n_mismatch = n_mismatch + 1;
		complete_run;
	end
	initial begin
		repeat (4) @(negedge core_clk);
		nrst = 1'b1;
		op(16'h0AB5);
		op(16'h0AAF);
		chk("w", workingRegister, 8'hB5);
		chk("neg", flagNegative, 1'b1);
		op(16'h0A1A);
		idle;
		chk("zero", flagZero, 1'b1);
		for (k = 0; k < 5; k = k + 1) op(16'hE8BF);
		op(16'hE805);
		op(16'hE850);
		op(16'hE9A3);
		idle;
		chk("ptr0", pointer0, 12'h005);
		chk("ptr1", pointer1, 12'h010);
		chk("ptr2", pointer2, 12'h118);
		op(16'hEA77);
		idle;
		chk("push", mdl.mem[12'h118], 8'h77);
		op(16'hE9C2);
		op(16'h0AFF);
		op(16'hE8C4);
		op(16'h0AFF);
		idle;
		chk("w", workingRegister, 8'h00);
		chk("ptr2", pointer2, 12'h119);
		op(16'hEB03);
		op(16'hF200);
		op(16'hEB85);
		op(16'hF006);
		op(16'h0014);
		#1;
		chk("call push", stackPush, 1'b1);
		chk("call ret addr", stackPushValue, 21'h000102);
		chk("call target", pcLoadValue, 21'h001000);
		op(16'h0AFF);
		idle;
		chk("indexed_to_absolute_move", mdl.mem[12'h200], 8'h46);
		chk("indexed_to_indexed_move", mdl.mem[12'h11F], 8'h44);
		chk("w", workingRegister, 8'h00);
		bankSelectRegister = 8'h02;
		mdl.mem[12'h280] = 8'h00;
		op(16'h6780);
		op(16'h0A01);
		op(16'h6780);
		op(16'hEF00);
		op(16'hF000);
		op(16'h0A55);
		op(16'h6781);
		op(16'h0A0F);
		op(16'h1A05);
		op(16'h1805);
		idle;
		chk("w", workingRegister, 8'h44);
		chk("xor_w_with_register", mdl.mem[12'h11E], 8'h1E);
		extensionEnableConfig = 1'b0;
		op(16'hE8BF);
		op(16'h1A05);
		op(16'h000D);
		op(16'h000F);
		idle;
		chk("ptr2", pointer2, 12'h119);
		chk("access", mdl.mem[12'h005], 8'h1B);
		chk("table_pointer", tablePointer, 22'h000002);
		extensionEnableConfig = 1'b1;
		op(16'hE8C0);
		#1;
		chk("pop", stackPop, 1'b1);
		chk("ret target", pcLoadValue, 21'h001234);
		op(16'hEF00);
		op(16'h0A0F);
		for (k = 0; k < 5; k = k + 1) op(16'hE9BF);
		op(16'hEB80);
		op(16'hF022);
		op(16'hEBA1);
		op(16'hF001);
		idle;
		chk("w", workingRegister, 8'h4B);
		chk("ptr2", pointer2, 12'hFDE);
		chk("zero src", mdl.mem[12'h000], 8'h00);
		chk("nop dst", mdl.mem[12'hFDF], 8'h85);
		complete_run;
	end
endmodule // cpu_extended_instruction_execute_bench
